// ### core/fme_pkg.sv
// Function
// - first metadata byte goes to pixel (0,0), then rightward along row zero.
// - embed values latched at the moment shutter integration ends.
// - each enabled item takes one 32-bit slot of four consecutive bytes.
// - in 8-bit pixel format a slot spans four pixels, one byte each.
// - all items enabled overwrites exactly the first forty bytes.
// - all enabled puts timestamp at byte 0, gain at 4, frame counter at 24.
// - only enabled items are packed, gap free; a lone item sits at byte 0.
// - monochrome build keeps the white balance slot but fills it with nothing useful.
// - item selection lives in the control register at offset 12f8h.
// - the bus time counter is readable at offset 1ea8h.
// - optionally the low four sub-tick bits carry the frame counter low bits.
// - sub-tick counts from zero to a limit whose span equals one tick.
// - tick counts 0 to 7999, eight thousand ticks per second.
// - seconds count 0 to 127 and wrap.
// - each field returns to zero after its cycle; all but seconds carry into the next.
// - ROI slot holds horizontal offset in first two bytes, vertical in next two.
package fme_pkg;
  localparam logic [15:0] CTRL_ADDR      = 16'h12f8;
  localparam logic [15:0] BUS_TIME_ADDR  = 16'h1ea8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_07ff;
  localparam logic [31:0] PRDATA_RESET   = 32'h0000_0000;

  localparam int          NUM_ITEMS      = 10;
  localparam int          ITEM_TS        = 0;
  localparam int          ITEM_GAIN      = 1;
  localparam int          ITEM_SHUTTER   = 2;
  localparam int          ITEM_BRIGHT    = 3;
  localparam int          ITEM_EXPOSURE  = 4;
  localparam int          ITEM_WB        = 5;
  localparam int          ITEM_FRAME     = 6;
  localparam int          ITEM_STROBE    = 7;
  localparam int          ITEM_GPIO      = 8;
  localparam int          ITEM_ROI       = 9;
  localparam int          CTRL_SUBST_BIT = 10;

  localparam logic [5:0]  EMBED_BYTES_MAX = 6'h28;
  localparam logic [3:0]  SLOT_CNT_RESET  = 4'h0;
  localparam int          GPIO_W         = 4;
  localparam int          SUBST_W        = 4;

  localparam int          SEC_W          = 7;
  localparam int          TICK_W         = 13;
  localparam int          SUB_W          = 12;
  localparam logic [6:0]  SEC_MAX        = 7'h7f;
  localparam logic [12:0] TICK_MAX       = 13'h1f3f;

  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          TICK_PERIOD_NS = 125000;
  localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          SUBTICK_DIV    = 2;

  typedef enum logic [1:0] {
    FME_DEC_NONE,
    FME_DEC_CTRL,
    FME_DEC_TIME
  } fme_dec_t;
endpackage

// ### core/fme_embedder.sv
`timescale 1ns/100ps
module fme_embedder #(
  parameter int TICK_CYCLES = fme_pkg::TICK_CYCLES,
  parameter bit MONO        = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shutter_end,
  input  wire logic [31:0] gain_val,
  input  wire logic [31:0] shutter_val,
  input  wire logic [31:0] brightness_val,
  input  wire logic [31:0] exposure_val,
  input  wire logic [31:0] wb_val,
  input  wire logic [31:0] strobe_count,
  input  wire logic [3:0]  gpio_pin,
  input  wire logic [15:0] roi_x,
  input  wire logic [15:0] roi_y,
  input  wire logic        pix_in_valid,
  input  wire logic        pix_in_sof,
  input  wire logic [7:0]  pix_in_data,
  output logic             pix_out_valid,
  output logic             pix_out_sof,
  output logic      [7:0]  pix_out_data
);

  localparam logic [11:0] SUB_MAX = 12'(TICK_CYCLES / fme_pkg::SUBTICK_DIV - 1);
  localparam logic [3:0]  DIV_MAX = 4'(fme_pkg::SUBTICK_DIV - 1);

  function automatic fme_pkg::fme_dec_t addr_decode(input logic [15:0] a);
    if (a == fme_pkg::CTRL_ADDR) begin
      return fme_pkg::FME_DEC_CTRL;
    end else if (a == fme_pkg::BUS_TIME_ADDR) begin
      return fme_pkg::FME_DEC_TIME;
    end
    return fme_pkg::FME_DEC_NONE;
  endfunction

  // ---------------- timestamp counter
  logic [3:0]  div_reg;
  logic [3:0]  div_next;
  logic [11:0] sub_reg;
  logic [11:0] sub_next;
  logic [12:0] tick_reg;
  logic [12:0] tick_next;
  logic [6:0]  sec_reg;
  logic [6:0]  sec_next;
  logic [31:0] bus_time;

  // sub-tick runs at half rate so a full tick span fits in twelve bits
  always_comb begin
    div_next  = div_reg + 4'h1;
    sub_next  = sub_reg;
    tick_next = tick_reg;
    sec_next  = sec_reg;
    if (div_reg == DIV_MAX) begin
      div_next = 4'h0;
      if (sub_reg == SUB_MAX) begin
        sub_next = 12'h000;
        if (tick_reg == fme_pkg::TICK_MAX) begin
          tick_next = 13'h0000;
          if (sec_reg == fme_pkg::SEC_MAX) begin
            sec_next = 7'h00;
          end else begin
            sec_next = sec_reg + 7'h01;
          end
        end else begin
          tick_next = tick_reg + 13'h0001;
        end
      end else begin
        sub_next = sub_reg + 12'h001;
      end
    end
  end

  assign bus_time = {sec_reg, tick_reg, sub_reg};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_reg  <= 4'h0;
      sub_reg  <= 12'h000;
      tick_reg <= 13'h0000;
      sec_reg  <= 7'h00;
    end else begin
      div_reg  <= div_next;
      sub_reg  <= sub_next;
      tick_reg <= tick_next;
      sec_reg  <= sec_next;
    end
  end

  // ---------------- apb slave
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  fme_pkg::fme_dec_t dec;

  // one wait state: pready rises in the second access cycle
  always_comb begin
    dec          = addr_decode(paddr);
    ctrl_next    = ctrl_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = fme_pkg::PRDATA_RESET;
      case (dec)
        fme_pkg::FME_DEC_CTRL: begin
          if (!pwrite) begin
            prdata_next = ctrl_reg;
          end
        end
        fme_pkg::FME_DEC_TIME: begin
          if (!pwrite) begin
            prdata_next = bus_time;
          end else begin
            pslverr_next = 1'b1;
          end
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready_reg && pwrite && dec == fme_pkg::FME_DEC_CTRL) begin
      ctrl_next = pwdata & fme_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg    <= fme_pkg::CTRL_RESET;
      prdata_reg  <= fme_pkg::PRDATA_RESET;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------- gpio synchroniser and frame counter
  logic [3:0]  gpio_meta_reg;
  logic [3:0]  gpio_sync_reg;
  logic [31:0] frame_cnt_reg;
  logic [31:0] frame_cnt_next;

  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    if (shutter_end) begin
      frame_cnt_next = frame_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gpio_meta_reg <= 4'h0;
      gpio_sync_reg <= 4'h0;
      frame_cnt_reg <= 32'h0000_0000;
    end else begin
      gpio_meta_reg <= gpio_pin;
      gpio_sync_reg <= gpio_meta_reg;
      frame_cnt_reg <= frame_cnt_next;
    end
  end

  // ---------------- snapshot at end of integration
  logic [31:0] item_val [fme_pkg::NUM_ITEMS];
  logic [31:0] snap_reg [fme_pkg::NUM_ITEMS];
  logic [31:0] snap_next [fme_pkg::NUM_ITEMS];
  logic [3:0]  snap_cnt_reg;
  logic [3:0]  snap_cnt_next;
  logic [31:0] ts_val;

  always_comb begin
    ts_val = bus_time;
    if (ctrl_reg[fme_pkg::CTRL_SUBST_BIT]) begin
      ts_val[fme_pkg::SUBST_W-1:0] = frame_cnt_next[fme_pkg::SUBST_W-1:0];
    end
  end

  always_comb begin
    item_val[fme_pkg::ITEM_TS]       = ts_val;
    item_val[fme_pkg::ITEM_GAIN]     = gain_val;
    item_val[fme_pkg::ITEM_SHUTTER]  = shutter_val;
    item_val[fme_pkg::ITEM_BRIGHT]   = brightness_val;
    item_val[fme_pkg::ITEM_EXPOSURE] = exposure_val;
    item_val[fme_pkg::ITEM_WB]       = MONO ? 32'h0000_0000 : wb_val;
    item_val[fme_pkg::ITEM_FRAME]    = frame_cnt_next;
    item_val[fme_pkg::ITEM_STROBE]   = strobe_count;
    item_val[fme_pkg::ITEM_GPIO]     = {28'h000_0000, gpio_sync_reg};
    item_val[fme_pkg::ITEM_ROI]      = {roi_x, roi_y};
  end

  // enabled items are compacted in fixed order; mask sampled at shutter end
  always_comb begin
    automatic logic [3:0] k;
    k = 4'h0;
    snap_next     = snap_reg;
    snap_cnt_next = snap_cnt_reg;
    if (shutter_end) begin
      for (int i = 0; i < fme_pkg::NUM_ITEMS; i++) begin
        snap_next[i] = 32'h0000_0000;
      end
      for (int i = 0; i < fme_pkg::NUM_ITEMS; i++) begin
        if (ctrl_reg[i]) begin
          snap_next[k] = item_val[i];
          k = k + 4'h1;
        end
      end
      snap_cnt_next = k;
    end
  end

  // ---------------- frame copy taken at start of frame
  logic [31:0] frame_reg [fme_pkg::NUM_ITEMS];
  logic [31:0] frame_next [fme_pkg::NUM_ITEMS];
  logic [3:0]  frame_slots_reg;
  logic [3:0]  frame_slots_next;

  // second copy keeps a late shutter end from tearing the header in flight
  always_comb begin
    frame_next       = frame_reg;
    frame_slots_next = frame_slots_reg;
    if (pix_in_valid && pix_in_sof) begin
      frame_next       = snap_reg;
      frame_slots_next = snap_cnt_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < fme_pkg::NUM_ITEMS; i++) begin
        snap_reg[i]  <= 32'h0000_0000;
        frame_reg[i] <= 32'h0000_0000;
      end
      snap_cnt_reg    <= fme_pkg::SLOT_CNT_RESET;
      frame_slots_reg <= fme_pkg::SLOT_CNT_RESET;
    end else begin
      snap_reg        <= snap_next;
      frame_reg       <= frame_next;
      snap_cnt_reg    <= snap_cnt_next;
      frame_slots_reg <= frame_slots_next;
    end
  end

  // ---------------- pixel path
  logic [5:0]  pos_reg;
  logic [5:0]  pos_next;
  logic [5:0]  bpos;
  logic [3:0]  slots;
  logic [31:0] word;
  logic [1:0]  sel;
  logic [7:0]  meta_byte;
  logic        embed;
  logic        out_valid_reg;
  logic        out_valid_next;
  logic        out_sof_reg;
  logic        out_sof_next;
  logic [7:0]  out_data_reg;
  logic [7:0]  out_data_next;

  always_comb begin
    bpos      = pix_in_sof ? 6'h00 : pos_reg;
    slots     = pix_in_sof ? snap_cnt_reg : frame_slots_reg;
    word      = pix_in_sof ? snap_reg[bpos[5:2]] : frame_reg[bpos[5:2]];
    sel       = 2'h3 - bpos[1:0];
    meta_byte = 8'(word >> {sel, 3'b000});
    embed     = (bpos < fme_pkg::EMBED_BYTES_MAX) && (bpos[5:2] < slots);
    pos_next  = pos_reg;
    if (pix_in_valid) begin
      if (pix_in_sof) begin
        pos_next = 6'h01;
      end else if (pos_reg < fme_pkg::EMBED_BYTES_MAX) begin
        pos_next = pos_reg + 6'h01;
      end
    end
    out_valid_next = pix_in_valid;
    out_sof_next   = pix_in_valid && pix_in_sof;
    out_data_next  = out_data_reg;
    if (pix_in_valid) begin
      out_data_next = embed ? meta_byte : pix_in_data;
    end
  end

  // no embedding until the first start of frame is seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos_reg       <= fme_pkg::EMBED_BYTES_MAX;
      out_valid_reg <= 1'b0;
      out_sof_reg   <= 1'b0;
      out_data_reg  <= 8'h00;
    end else begin
      pos_reg       <= pos_next;
      out_valid_reg <= out_valid_next;
      out_sof_reg   <= out_sof_next;
      out_data_reg  <= out_data_next;
    end
  end

  assign pix_out_valid = out_valid_reg;
  assign pix_out_sof   = out_sof_reg;
  assign pix_out_data  = out_data_reg;

endmodule

// ### sim/fme_embedder_chk.sv
`timescale 1ns/100ps
module fme_embedder_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pix_in_valid,
  input wire logic        pix_in_sof,
  input wire logic        pix_out_valid,
  input wire logic        pix_out_sof,
  input wire logic [7:0]  pix_out_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  assign acc = psel && penable && !pready;
  one_wait_a: assert property (acc |=> pready) else $error("no ready after wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_pair_a: assert property (pslverr |-> pready) else $error("stray error");
  ctrl_ok_a: assert property (acc && paddr == fme_pkg::CTRL_ADDR |=> !pslverr)
    else $error("control access refused");
  unmapped_err_a: assert property (acc && paddr != fme_pkg::CTRL_ADDR
    && paddr != fme_pkg::BUS_TIME_ADDR |=> pslverr) else $error("unmapped accepted");
  time_ro_a: assert property (acc && pwrite && paddr == fme_pkg::BUS_TIME_ADDR |=> pslverr)
    else $error("time write accepted");
  pix_lat_a: assert property (pix_in_valid |=> pix_out_valid) else $error("pixel lost");
  pix_idle_a: assert property (!pix_in_valid |=> !pix_out_valid) else $error("extra pixel");
  sof_pos_a: assert property (pix_in_valid && pix_in_sof |=> pix_out_sof)
    else $error("start pixel moved");
  out_hold_a: assert property (!pix_out_valid |-> $stable(pix_out_data))
    else $error("idle data moved");
  cover property (pslverr);
  cover property (pix_in_valid && pix_in_sof);
  cover property (acc && pwrite && paddr == fme_pkg::CTRL_ADDR);
endmodule

bind fme_embedder fme_embedder_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pix_in_valid(pix_in_valid), .pix_in_sof(pix_in_sof), .pix_out_valid(pix_out_valid),
  .pix_out_sof(pix_out_sof), .pix_out_data(pix_out_data));

// ### sim/fme_pixel_sink.sv
`timescale 1ns/100ps
module fme_pixel_sink (
  input wire logic       sys_clk,
  input wire logic       pix_out_valid,
  input wire logic       pix_out_sof,
  input wire logic [7:0] pix_out_data
);
  logic [7:0]  got [64];
  logic [31:0] ts_seen;
  int          idx = 0;
  // no back-pressure: every valid byte is taken at once
  always @(posedge sys_clk) begin
    if (pix_out_valid) begin
      got[pix_out_sof ? 0 : idx] <= pix_out_data;
      idx <= pix_out_sof ? 1 : idx + 1;
    end
  end
  // low nibble not trusted as sub-tick
  assign ts_seen = {got[0], got[1], got[2], got[3] & 8'hf0};
endmodule

// ### sim/fme_embedder_tb_top.sv
`timescale 1ns/100ps
module fme_embedder_tb_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, shutter_end = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic        pix_in_valid = 1'b0, pix_in_sof = 1'b0;
  logic [15:0] paddr = 16'h0000, roi_x = 16'h0123, roi_y = 16'h0456;
  logic [31:0] pwdata = 32'h0, gain_val = 32'h1111_2222, shutter_val = 32'h3333_4444;
  logic [31:0] brightness_val = 32'h5a5a_0101, exposure_val = 32'hc3d4_e5f6;
  logic [31:0] wb_val = 32'h0bad_cafe, strobe_count = 32'h0000_0777, rd, prev;
  logic [3:0]  gpio_pin = 4'ha;
  logic [7:0]  pix_in_data = 8'h00;
  logic [31:0] prdata, w [10];
  logic        pready, pslverr, pix_out_valid, pix_out_sof, mono_valid, mono_sof;
  logic [7:0]  pix_out_data, mono_data;
  int          mismatches = 0, checks = 0;

  always #10 sys_clk = ~sys_clk;

  fme_embedder #(.TICK_CYCLES(40), .MONO(1'b0)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .shutter_end(shutter_end),
    .gain_val(gain_val), .shutter_val(shutter_val), .brightness_val(brightness_val),
    .exposure_val(exposure_val), .wb_val(wb_val), .strobe_count(strobe_count),
    .gpio_pin(gpio_pin), .roi_x(roi_x), .roi_y(roi_y), .pix_in_valid(pix_in_valid),
    .pix_in_sof(pix_in_sof), .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
    .pix_out_sof(pix_out_sof), .pix_out_data(pix_out_data));

  fme_pixel_sink i_sink (.sys_clk(sys_clk), .pix_out_valid(pix_out_valid),
    .pix_out_sof(pix_out_sof), .pix_out_data(pix_out_data));

  // monochrome build on the same stimulus; only its wb slot is compared
  fme_embedder #(.TICK_CYCLES(40), .MONO(1'b1)) i_dut_mono (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .shutter_end(shutter_end),
    .gain_val(gain_val), .shutter_val(shutter_val), .brightness_val(brightness_val),
    .exposure_val(exposure_val), .wb_val(wb_val), .strobe_count(strobe_count),
    .gpio_pin(gpio_pin), .roi_x(roi_x), .roi_y(roi_y), .pix_in_valid(pix_in_valid),
    .pix_in_sof(pix_in_sof), .pix_in_data(pix_in_data), .pix_out_valid(mono_valid),
    .pix_out_sof(mono_sof), .pix_out_data(mono_data));

  fme_pixel_sink i_sink_mono (.sys_clk(sys_clk), .pix_out_valid(mono_valid),
    .pix_out_sof(mono_sof), .pix_out_data(mono_data));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, seen);
    end
  endtask

  // one idle edge after each transfer so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic shot;
    shutter_end <= 1'b1;
    @(posedge sys_clk);
    shutter_end <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic send_frame(input int n);
    for (int i = 0; i < n; i++) begin
      pix_in_valid <= 1'b1;
      pix_in_sof <= (i == 0);
      pix_in_data <= 8'(i) + 8'h80;
      @(posedge sys_clk);
    end
    pix_in_valid <= 1'b0;
    pix_in_sof <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic frame_chk(input int c);
    logic [7:0] e;
    for (int k = 0; k < 4 * c + 4; k++) begin
      e = (k < 4 * c) ? w[k / 4][31 - 8 * (k % 4) -: 8] : 8'(k) + 8'h80;
      chk("pixel", {24'h0, e}, {24'h0, i_sink.got[k]});
    end
  endtask

  // sub-tick span is 20 with TICK_CYCLES of 40; reads sit 4 clocks apart
  function automatic logic [31:0] adv2(input logic [31:0] t);
    logic [11:0] s;
    logic [12:0] k;
    s = t[11:0] + 12'h002;
    k = t[24:12];
    if (s >= 12'h014) begin
      s = s - 12'h014;
      k = k + 13'h0001;
    end
    return {t[31:25], k, s};
  endfunction

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, fme_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", fme_pkg::CTRL_RESET, rd);
    apb(1'b1, fme_pkg::CTRL_ADDR, 32'hffff_ffff);
    apb(1'b0, fme_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl mask", fme_pkg::CTRL_MASK, rd);
    apb(1'b1, fme_pkg::BUS_TIME_ADDR, 32'h0);
    chk("time write err", 32'h1, {31'h0, er});
    apb(1'b0, 16'h0004, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, fme_pkg::BUS_TIME_ADDR, 32'h0);
    for (int i = 0; i < 12; i++) begin
      prev = rd;
      apb(1'b0, fme_pkg::BUS_TIME_ADDR, 32'h0);
      chk("bus time", adv2(prev), rd);
    end
    apb(1'b1, fme_pkg::CTRL_ADDR, 32'h0000_0010);
    shot();
    send_frame(48);
    w[0] = exposure_val;
    frame_chk(1);
    apb(1'b1, fme_pkg::CTRL_ADDR, 32'h0000_07ff);
    apb(1'b0, fme_pkg::BUS_TIME_ADDR, 32'h0);
    // read sampled four clocks before the shutter edge: two sub-tick steps apart
    prev = adv2(rd);
    @(posedge sys_clk);
    shot();
    gain_val <= 32'h5555_6666;
    send_frame(48);
    w = '{32'h0, 32'h1111_2222, shutter_val, brightness_val, exposure_val, wb_val,
      32'h2, strobe_count, {28'h0, gpio_pin}, {roi_x, roi_y}};
    // low nibble carries frame counter low bits
    w[0] = {prev[31:4], 4'h2};
    chk("ts seen", {prev[31:4], 4'h0}, i_sink.ts_seen);
    chk("mono wb", 32'h0, {i_sink_mono.got[20], i_sink_mono.got[21], i_sink_mono.got[22],
      i_sink_mono.got[23]});
    frame_chk(10);
    close_out();
  end
endmodule
